//--- logic/paged_regs_pkg.sv
// Package for the paged register bank: addresses, field positions, reset values, format codes.
// Assumes a byte-wide register port decoded inside book and page.
package paged_regs_pkg;

  // Book/page locations of each register
  localparam logic [7:0] BOOK_ZERO        = 8'h00;
  localparam logic [7:0] PAGE_ZERO        = 8'h00;
  localparam logic [7:0] PAGE_ONE         = 8'h01;
  localparam logic [6:0] ADDR_FAULT_FLAGS = 7'h6c;
  localparam logic [6:0] ADDR_LOW_POWER   = 7'h79;
  localparam logic [6:0] ADDR_BOOK_SEL    = 7'h7f;
  localparam logic [6:0] ADDR_PAGE_SEL    = 7'h00;
  localparam logic [6:0] ADDR_FORMAT      = 7'h01;
  localparam logic [6:0] ADDR_OFFSET      = 7'h03;

  // Reset values
  localparam logic [7:0] RST_FAULT_FLAGS  = 8'h00;
  localparam logic [7:0] RST_LOW_POWER    = 8'h00;
  localparam logic [7:0] RST_BOOK_SEL     = 8'h00;
  localparam logic [7:0] RST_PAGE_SEL     = 8'h01;
  localparam logic [7:0] RST_FORMAT       = 8'h10;
  localparam logic [7:0] RST_OFFSET       = 8'h00;

  // Field positions
  localparam int FLAG_A_BIT   = 3;
  localparam int FLAG_B_BIT   = 2;
  localparam int SHUTDOWN_BIT = 7;
  localparam int FMT_MSB      = 7;
  localparam int FMT_LSB      = 5;
  localparam int LEN_MSB      = 4;
  localparam int LEN_LSB      = 3;
  localparam int HIZ_BIT      = 0;

  // Serial audio format codes
  typedef enum logic [2:0] {
    FMT_I2S   = 3'h0,
    FMT_DSP   = 3'h1,
    FMT_RIGHT = 3'h2,
    FMT_LEFT  = 3'h3,
    FMT_MONO  = 3'h4
  } audio_format_t;

  // Word length codes and bit counts
  localparam logic [5:0] LEN_16 = 6'h10;
  localparam logic [5:0] LEN_20 = 6'h14;
  localparam logic [5:0] LEN_24 = 6'h18;
  localparam logic [5:0] LEN_32 = 6'h20;

  // Register access request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Decoded serial port settings
  typedef struct packed {
    logic [2:0] audio_format_select;
    logic       format_valid;
    logic [5:0] word_bits;
    logic       data_out_hiz_enable;
    logic [7:0] audio_data_offset;
  } port_cfg_t;

endpackage

//--- logic/paged_regs_asi_format.sv
// Paged register bank: clock fault flags, low power control, book/page select, serial audio format.
// Assumes one-cycle rd/wr strobes from the control bus front end, synchronous to I_REF_CLK.
`timescale 1ns/1ps

// How it works
// - The fault flag register keeps each flag set until a read, which returns the flags and clears them.
// - Bit 3 of the fault flag register shows whether clock fault A happened since the last read.
// - Bit 2 shows whether clock fault B happened since the last read, and all other bits read zero.
// - Bit 7 of the low power register set to 1 disables power-on reset and enters shutdown, 0 keeps normal running.
// - The book register at 0x7f picks any of 256 books for later accesses.
// - The page register at 0x00 picks the page for the next access and resets to page 1.
// - Format bits 7 to 5 pick I2S, DSP, right justified, left justified or mono PCM, higher codes reserved.
// - Word length bits 4 to 3 pick 16, 20, 24 or 32 bits, with 24 after reset.
// - Format bit 0 set makes the data output float for the leftover bit clocks of each frame.
// - The offset value delays the start of serial data, from the word clock rising edge in DSP format.
// - The offset has no effect in right justified format.
module paged_regs_asi_format (
  input  wire logic                       I_REF_CLK,       // Register clock
  input  wire logic                       I_RSTN,          // Async reset, active low
  input  wire paged_regs_pkg::reg_req_t   I_REQ,           // Register access request
  input  wire logic                       I_CLK_FAULT_A,   // Clock fault A event
  input  wire logic                       I_CLK_FAULT_B,   // Clock fault B event
  output logic [7:0]                      O_RDATA,         // Read data, registered
  output logic                            O_RVALID,        // Read data valid pulse
  output logic                            O_POR_DISABLE,   // Power-on reset disabled
  output logic                            O_SHUTDOWN,      // Low power shutdown mode
  output logic [7:0]                      O_BOOK,          // Current book
  output logic [7:0]                      O_PAGE,          // Current page
  output paged_regs_pkg::port_cfg_t       O_PORT_CFG       // Serial port settings
);

  logic [1:0] flags_reg;
  logic [1:0] flags_next;
  logic [7:0] low_power_reg;
  logic [7:0] book_reg;
  logic [7:0] page_reg;
  logic [7:0] format_reg;
  logic [7:0] offset_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       rvalid_reg;

  // Book and page decode of the current access
  wire in_b0      = (book_reg == paged_regs_pkg::BOOK_ZERO);
  wire in_p0      = in_b0 && (page_reg == paged_regs_pkg::PAGE_ZERO);
  wire in_p1      = in_b0 && (page_reg == paged_regs_pkg::PAGE_ONE);
  wire hit_page   = (I_REQ.addr == paged_regs_pkg::ADDR_PAGE_SEL);
  wire hit_book   = in_p0 && (I_REQ.addr == paged_regs_pkg::ADDR_BOOK_SEL);
  wire hit_flags  = in_p0 && (I_REQ.addr == paged_regs_pkg::ADDR_FAULT_FLAGS);
  wire hit_lowpwr = in_p0 && (I_REQ.addr == paged_regs_pkg::ADDR_LOW_POWER);
  wire hit_format = in_p1 && (I_REQ.addr == paged_regs_pkg::ADDR_FORMAT);
  wire hit_offset = in_p1 && (I_REQ.addr == paged_regs_pkg::ADDR_OFFSET);
  wire flag_read  = I_REQ.rd && hit_flags;

  // Sticky flags, a new event wins over the read clear
  wire [1:0] flag_events = {I_CLK_FAULT_A, I_CLK_FAULT_B};
  assign flags_next = (flag_read ? 2'h0 : flags_reg) | flag_events;

  // Read mux, fault register shows only its two flags
  wire [7:0] flags_view = {4'h0, flags_reg, 2'h0};
  always_comb begin
    rdata_next = 8'h00;
    if (hit_page)
      rdata_next = page_reg;
    else if (hit_book)
      rdata_next = book_reg;
    else if (hit_flags)
      rdata_next = flags_view;
    else if (hit_lowpwr)
      rdata_next = low_power_reg;
    else if (hit_format)
      rdata_next = format_reg;
    else if (hit_offset)
      rdata_next = offset_reg;
  end

  // Flag and read data registers
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      flags_reg  <= 2'h0;
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      flags_reg  <= flags_next;
      rvalid_reg <= I_REQ.rd;
      if (I_REQ.rd)
        rdata_reg <= rdata_next;
    end
  end

  // Checks on the sticky flags and the read port
  property p_flag_sticky;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
      (flags_reg[1] && !flag_read) |=> flags_reg[1];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag a dropped before read");

  property p_flag_sticky_b;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
      (flags_reg[0] && !flag_read) |=> flags_reg[0];
  endproperty
  a_flag_sticky_b: assert property (p_flag_sticky_b) else $error("flag b dropped before read");

  property p_flag_clear;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
      (flag_read && !I_CLK_FAULT_A) |=> !flags_reg[1];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag a not cleared by read");

  property p_flag_clear_b;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
      (flag_read && !I_CLK_FAULT_B) |=> !flags_reg[0];
  endproperty
  a_flag_clear_b: assert property (p_flag_clear_b) else $error("flag b not cleared by read");

  property p_flag_set_a;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
      I_CLK_FAULT_A |=> flags_reg[1];
  endproperty
  a_flag_set_a: assert property (p_flag_set_a) else $error("fault a not caught");

  property p_flag_set_b;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
      I_CLK_FAULT_B |=> flags_reg[0];
  endproperty
  a_flag_set_b: assert property (p_flag_set_b) else $error("fault b not caught");

  property p_flag_no_raise;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
      (!I_CLK_FAULT_A && !flags_reg[1]) |=> !flags_reg[1];
  endproperty
  a_flag_no_raise: assert property (p_flag_no_raise) else $error("flag a set without event");

  property p_flag_read_a;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
      flag_read |=> O_RDATA[paged_regs_pkg::FLAG_A_BIT] == $past(flags_reg[1]);
  endproperty
  a_flag_read_a: assert property (p_flag_read_a) else $error("fault a read wrong");

  property p_flag_read_b;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
      flag_read |=> (O_RDATA[paged_regs_pkg::FLAG_B_BIT] == $past(flags_reg[0]))
        && (O_RDATA[7:4] == 4'h0) && (O_RDATA[1:0] == 2'h0);
  endproperty
  a_flag_read_b: assert property (p_flag_read_b) else $error("fault b read wrong");

  property p_rvalid_pulse;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
      I_REQ.rd |=> O_RVALID;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read not answered");

  property p_rvalid_idle;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
      !I_REQ.rd |=> !O_RVALID;
  endproperty
  a_rvalid_idle: assert property (p_rvalid_idle) else $error("read valid without read");

  property p_rdata_hold;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
      !I_REQ.rd |=> $stable(O_RDATA);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without read");

  property p_unmapped_read;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
      (I_REQ.rd && !(hit_page || hit_book || hit_flags || hit_lowpwr || hit_format || hit_offset))
        |=> O_RDATA == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  // Writable control registers, held until rewritten
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      low_power_reg <= paged_regs_pkg::RST_LOW_POWER;
      book_reg      <= paged_regs_pkg::RST_BOOK_SEL;
      page_reg      <= paged_regs_pkg::RST_PAGE_SEL;
      format_reg    <= paged_regs_pkg::RST_FORMAT;
      offset_reg    <= paged_regs_pkg::RST_OFFSET;
    end else if (I_REQ.wr) begin
      if (hit_page)
        page_reg <= I_REQ.wdata;
      if (hit_book)
        book_reg <= I_REQ.wdata;
      if (hit_lowpwr)
        low_power_reg <= I_REQ.wdata;
      if (hit_format)
        format_reg <= I_REQ.wdata;
      if (hit_offset)
        offset_reg <= I_REQ.wdata;
    end
  end

  // Checks on the writable registers
  property p_page_write;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
      (I_REQ.wr && hit_page) |=> page_reg == $past(I_REQ.wdata);
  endproperty
  a_page_write: assert property (p_page_write) else $error("page write lost");

  property p_page_hold;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
      !(I_REQ.wr && hit_page) |=> $stable(page_reg);
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page changed unasked");

  property p_book_write;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
      (I_REQ.wr && hit_book) |=> book_reg == $past(I_REQ.wdata);
  endproperty
  a_book_write: assert property (p_book_write) else $error("book write lost");

  property p_book_hold;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
      !(I_REQ.wr && hit_book) |=> $stable(book_reg);
  endproperty
  a_book_hold: assert property (p_book_hold) else $error("book changed unasked");

  property p_shutdown;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
      (I_REQ.wr && hit_lowpwr) |=> (O_SHUTDOWN == $past(I_REQ.wdata[7]))
        && (O_POR_DISABLE == $past(I_REQ.wdata[7]));
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown bit wrong");

  property p_foreign_book;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
      (I_REQ.wr && (book_reg != 8'h00) && !hit_page) |=> $stable({low_power_reg, format_reg, offset_reg});
  endproperty
  a_foreign_book: assert property (p_foreign_book) else $error("write landed outside its book");

  // Format decode
  wire [2:0] fmt_code = format_reg[paged_regs_pkg::FMT_MSB:paged_regs_pkg::FMT_LSB];
  wire [1:0] len_code = format_reg[paged_regs_pkg::LEN_MSB:paged_regs_pkg::LEN_LSB];
  wire       fmt_ok   = (fmt_code <= 3'(paged_regs_pkg::FMT_MONO));
  wire       is_right = (fmt_code == 3'(paged_regs_pkg::FMT_RIGHT));
  logic [5:0] word_bits;
  always_comb begin
    case (len_code)
      2'h0:    word_bits = paged_regs_pkg::LEN_16;
      2'h1:    word_bits = paged_regs_pkg::LEN_20;
      2'h2:    word_bits = paged_regs_pkg::LEN_24;
      2'h3:    word_bits = paged_regs_pkg::LEN_32;
      default: word_bits = paged_regs_pkg::LEN_24;
    endcase
  end

  // Outputs straight from the registers, port settings through the format decode
  assign O_RDATA       = rdata_reg;
  assign O_RVALID      = rvalid_reg;
  assign O_POR_DISABLE = low_power_reg[paged_regs_pkg::SHUTDOWN_BIT];
  assign O_SHUTDOWN    = low_power_reg[paged_regs_pkg::SHUTDOWN_BIT];
  assign O_BOOK        = book_reg;
  assign O_PAGE        = page_reg;
  assign O_PORT_CFG = '{
    audio_format_select: fmt_code,
    format_valid:        fmt_ok,
    word_bits:           word_bits,
    data_out_hiz_enable: format_reg[paged_regs_pkg::HIZ_BIT],
    audio_data_offset:   is_right ? 8'h00 : offset_reg
  };

  // Checks on the decoded port settings
  property p_len_map;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
      (len_code == 2'h2) |-> O_PORT_CFG.word_bits == 6'h18;
  endproperty
  a_len_map: assert property (p_len_map) else $error("word length wrong");

  property p_len_16;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
      (len_code == 2'h0) |-> O_PORT_CFG.word_bits == 6'h10;
  endproperty
  a_len_16: assert property (p_len_16) else $error("short word length wrong");

  property p_len_32;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
      (len_code == 2'h3) |-> O_PORT_CFG.word_bits == 6'h20;
  endproperty
  a_len_32: assert property (p_len_32) else $error("long word length wrong");

  property p_right_no_offset;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
      is_right |-> O_PORT_CFG.audio_data_offset == 8'h00;
  endproperty
  a_right_no_offset: assert property (p_right_no_offset) else $error("offset in right justified");

  property p_offset_pass;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
      !is_right |-> O_PORT_CFG.audio_data_offset == offset_reg;
  endproperty
  a_offset_pass: assert property (p_offset_pass) else $error("offset not passed on");

  property p_fmt_valid;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
      (fmt_code > 3'h4) |-> !O_PORT_CFG.format_valid;
  endproperty
  a_fmt_valid: assert property (p_fmt_valid) else $error("reserved format valid");

  property p_fmt_ok;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
      (fmt_code <= 3'h4) |-> O_PORT_CFG.format_valid;
  endproperty
  a_fmt_ok: assert property (p_fmt_ok) else $error("known format marked invalid");

  property p_hiz;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
      O_PORT_CFG.data_out_hiz_enable == format_reg[0];
  endproperty
  a_hiz: assert property (p_hiz) else $error("float enable wrong");

endmodule // paged_regs_asi_format

//--- bench/host_model.sv
// Host model: single-byte register writes and reads on the request port.
// Assumes strobes are taken on the rising edge and read data comes one cycle later.
`timescale 1ns/1ps
module host_model (
  input  wire logic                 i_clk,    // Register clock
  input  wire logic [7:0]           i_rdata,  // Read data
  input  wire logic                 i_rvalid, // Read data valid
  output paged_regs_pkg::reg_req_t  o_req     // Request to the bank
);
  // Idle request; released fields show inverted values, never stale ones
  initial o_req = '{wr: 1'b0, rd: 1'b0, addr: 7'h7f, wdata: 8'hff};
  // One write strobe, then release
  task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk);
    o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // One read strobe; answer taken in the cycle after the taking edge
  task automatic read_reg(input logic [6:0] a, output logic [7:0] d, output logic v);
    @(posedge i_clk);
    o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk);
    o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
    #1;
    v = i_rvalid;
    d = i_rdata;
  endtask
endmodule // host_model

//--- bench/paged_regs_asi_format_tb.sv
// Bench for the paged register bank: reset values, sticky flags, low power, format, offset, book and page.
// Assumes host_model makes every register access.
`timescale 1ns/1ps
module paged_regs_asi_format_tb;
  logic                      ref_clk     = 1'b0;
  logic                      rstn        = 1'b0;
  logic                      flt_a       = 1'b0;
  logic                      flt_b       = 1'b0;
  paged_regs_pkg::reg_req_t  req;
  paged_regs_pkg::port_cfg_t cfg;
  logic [7:0]                rdata;
  logic [7:0]                book;
  logic [7:0]                page;
  logic                      rvalid;
  logic                      por_off;
  logic                      shut;
  int                        n_errors    = 0;
  int                        comparisons = 0;

  // 125 MHz clock
  always #4 ref_clk = ~ref_clk;

  paged_regs_asi_format u_dut (.I_REF_CLK(ref_clk), .I_RSTN(rstn), .I_REQ(req), .I_CLK_FAULT_A(flt_a),
    .I_CLK_FAULT_B(flt_b), .O_RDATA(rdata), .O_RVALID(rvalid), .O_POR_DISABLE(por_off),
    .O_SHUTDOWN(shut), .O_BOOK(book), .O_PAGE(page), .O_PORT_CFG(cfg));
  host_model u_host (.i_clk(ref_clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));

  // Expected port settings from format code, length code, float bit and offset
  function automatic logic [18:0] cfgx(input logic [2:0] f, input logic [1:0] l, input logic h,
                                       input logic [7:0] o);
    logic [5:0] w;
    w = (l == 2'h0) ? 6'h10 : (l == 2'h1) ? 6'h14 : (l == 2'h2) ? 6'h18 : 6'h20;
    return {f, f <= 3'h4, w, h, (f == 3'h2) ? 8'h00 : o};
  endfunction

  // Count and report one comparison
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Write and let it land
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.write_reg(a, d);
    @(posedge ref_clk);
    #1;
  endtask
  // Read, compare data and valid
  task automatic rd(input string name, input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    u_host.read_reg(a, d, v);
    check(name, {24'h0, exp}, {24'h0, d});
    check("rvalid", 32'h1, {31'h0, v});
  endtask
  // One-cycle fault events
  task automatic pulse(input logic [1:0] s);
    @(posedge ref_clk);
    flt_a <= s[1];
    flt_b <= s[0];
    @(posedge ref_clk);
    flt_a <= 1'b0;
    flt_b <= 1'b0;
  endtask
  // Reset held 20 cycles
  task automatic do_reset();
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic t_reset();
    check("book", 32'h0, book);
    check("page", 32'h1, page);
    check("cfg", cfgx(3'h0, 2'h2, 1'b0, 8'h00), cfg);
    check("lowpwr", 32'h0, {por_off, shut});
    rd("pagereg", 7'h00, 8'h01);
    rd("fmt", 7'h01, 8'h10);
    rd("ofs", 7'h03, 8'h00);
    wr(7'h00, 8'h00);
    rd("flags", 7'h6c, 8'h00);
    rd("lp", 7'h79, 8'h00);
    rd("bookreg", 7'h7f, 8'h00);
  endtask
  task automatic t_flags();
    pulse(2'b10);
    rd("flags", 7'h6c, 8'h08);
    rd("flags", 7'h6c, 8'h00);
    pulse(2'b01);
    rd("flags", 7'h6c, 8'h04);
    pulse(2'b11);
    repeat (5) @(posedge ref_clk);
    rd("flags", 7'h6c, 8'h0c);
    rd("flags", 7'h6c, 8'h00);
    // Event at the edge that takes the clearing read survives it
    pulse(2'b10);
    fork
      rd("flags", 7'h6c, 8'h08);
      pulse(2'b10);
    join
    rd("flags", 7'h6c, 8'h08);
    rd("flags", 7'h6c, 8'h00);
  endtask
  task automatic t_lowpower();
    wr(7'h79, 8'h80);
    check("lowpwr", 32'h3, {por_off, shut});
    rd("lp", 7'h79, 8'h80);
    wr(7'h79, 8'h01);
    check("lowpwr", 32'h0, {por_off, shut});
    rd("lp", 7'h79, 8'h01);
  endtask
  task automatic t_format();
    logic [7:0] f;
    wr(7'h00, 8'h01);
    for (int c = 0; c < 8; c++) begin
      f = {c[2:0], c[1:0], 2'b00, c[0]};
      wr(7'h01, f);
      check("cfg", cfgx(c[2:0], c[1:0], c[0], 8'h00), cfg);
      rd("fmt", 7'h01, f);
    end
  endtask
  task automatic t_offset();
    wr(7'h01, 8'h70);
    wr(7'h03, 8'h5a);
    check("cfg", cfgx(3'h3, 2'h2, 1'b0, 8'h5a), cfg);
    wr(7'h01, 8'h30);
    check("cfg", cfgx(3'h1, 2'h2, 1'b0, 8'h5a), cfg);
    wr(7'h01, 8'h50);
    check("cfg", cfgx(3'h2, 2'h2, 1'b0, 8'h00), cfg);
    rd("ofs", 7'h03, 8'h5a);
  endtask
  task automatic t_book();
    wr(7'h00, 8'h00);
    wr(7'h7f, 8'hff);
    check("book", 32'hff, book);
    rd("lp", 7'h79, 8'h00);
    wr(7'h00, 8'h01);
    check("page", 32'h1, page);
    rd("fmt", 7'h01, 8'h00);
    wr(7'h01, 8'h00);
    check("cfg", cfgx(3'h2, 2'h2, 1'b0, 8'h00), cfg);
    do_reset();
    check("book", 32'h0, book);
  endtask

  task automatic conclude();
    if (n_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    do_reset();
    t_reset();
    t_flags();
    t_lowpower();
    t_format();
    t_offset();
    t_book();
    conclude();
  end
endmodule // paged_regs_asi_format_tb
